// [include/fec_pkg.sv]
// fec_pkg: constants and carrier types for the flash erase control and memory select block.
// Assumes a 20 MHz clock and a synchronous, single-cycle write strobe from the bus front end.
package fec_pkg;

    // configuration-space register offsets (low address byte)
    localparam logic [7:0] OFS_PAGE = 8'hE0;
    localparam logic [7:0] OFS_PROT_PRIMARY = 8'hC0;
    localparam logic [7:0] OFS_PROT_SECONDARY = 8'hC1;
    localparam logic [7:0] OFS_SPACE_MAP = 8'hC2;

    // reset values
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] SPACE_MAP_INIT = 8'h0C;

    // space map bit positions
    localparam int MAP_SRAM_PROG = 0;
    localparam int MAP_SEC_PROG = 1;
    localparam int MAP_PRI_PROG = 2;
    localparam int MAP_SEC_DATA = 3;
    localparam int MAP_PRI_DATA = 4;

    // status byte bit positions
    localparam int STAT_TOGGLE = 6;
    localparam int STAT_ERROR = 5;
    localparam int STAT_WINDOW = 3;

    // command codes and unlock addresses
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [11:0] ADR_UNLOCK1 = 12'hAAA;
    localparam logic [11:0] ADR_UNLOCK2 = 12'h554;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_BULK = 8'h10;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESET = 8'hF0;

    // timing, figures in ns, counts at the clock rate
    localparam int CLK_PERIOD_NS = 50;
    localparam int SUSPEND_MIN_NS = 100;
    localparam int SUSPEND_MAX_NS = 15000;
    localparam int RECOVER_NS = 25000;
    localparam int WINDOW_NS = 100000;
    localparam int TMR_W = 12;
    localparam logic [TMR_W-1:0] SUSPEND_CYC =
        TMR_W'((SUSPEND_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] SUSPEND_MAX_CYC = TMR_W'(SUSPEND_MAX_NS / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] RECOVER_CYC = TMR_W'(RECOVER_NS / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] WINDOW_CYC = TMR_W'(WINDOW_NS / CLK_PERIOD_NS);

    // one bus cycle as seen by the block
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
        logic fetch;
        logic cfg;
    } fec_bus_t;

    // decoder selects
    typedef struct packed {
        logic [7:0] primary;
        logic [3:0] secondary;
        logic sram;
        logic io;
    } fec_sel_t;

    typedef enum logic [3:0] {
        ST_READ, ST_UNLK1, ST_UNLK2, ST_PROG_ADDR, ST_ERS_SETUP, ST_ERS_UNLK1,
        ST_ERS_UNLK2, ST_PROGRAM, ST_BULK, ST_WINDOW, ST_ERASING, ST_SUSPENDING,
        ST_SUSPENDED, ST_ERROR, ST_RECOVER
    } fec_state_t;

endpackage : fec_pkg

// [hw/fec_cycle_timer.sv]
// fec_cycle_timer: down counter for the erase window, suspend latency and recovery delay.
// Assumes load is a single-cycle pulse; a new load restarts the count.
`timescale 1ns/100ps
module fec_cycle_timer (
    input wire logic clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [fec_pkg::TMR_W-1:0] load_value,
    output logic done
);
    logic [fec_pkg::TMR_W-1:0] count_reg;
    logic [fec_pkg::TMR_W-1:0] count_next;
    logic run_reg;
    logic run_next;
    logic last;

    assign last = run_reg && (count_reg == fec_pkg::TMR_W'(1));
    assign count_next = load ? load_value : (run_reg ? count_reg - fec_pkg::TMR_W'(1) : count_reg);
    assign run_next = load ? 1'b1 : (last ? 1'b0 : run_reg);
    // done pulses in the cycle the count reaches its end
    assign done = last && !load;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
            run_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg <= run_next;
        end
    end
endmodule : fec_cycle_timer

// [hw/fec_flash_ctrl.sv]
// fec_flash_ctrl: flash command sequencer (suspend, resume, reset, protection) plus select
// priority, space mapping and the page register.
// Assumes bus fields are synchronous to clk and wr is high for one cycle per write.
// Overview of operation
// - suspend is B0 to even address with sector select
// - suspend only acts while erase is active
// - suspend during add-sector window ends window
// - toggle stops 0.1 to 15 us after suspend
// - suspended erasing sector reads invalid, others valid
// - suspended: only resume, reset and reads accepted
// - reset while suspended abandons erase, sector invalid
// - resume is 30 to even address with select
// - program and erase of protected sector ignored
// - protection bits readable, never writable by MCU
// - reset is one write, optional unlock prefix
// - reset gives read mode; after error or during sector erase within 25 us
// - reset ignored in program or bulk erase
// - chip reset aborts cycles, returns to read
// - sram and io over secondary over primary
// - space map steers program or data space answer
// - 0Ch separates spaces; b2 b4 combine primary
// - page register read and write at E0h
// - page bits feed decoder and general logic
// - window flag 0 while counting, 1 erasing
`timescale 1ns/100ps
module fec_flash_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire fec_pkg::fec_bus_t bus,
    input wire fec_pkg::fec_sel_t raw_sel,
    input wire logic [7:0] prot_primary,
    input wire logic [3:0] prot_secondary,
    input wire logic op_done,
    input wire logic op_fail,
    output fec_pkg::fec_sel_t sel_out,
    output logic [7:0] page_bits,
    output logic [7:0] rd_data,
    output logic status_drive,
    output logic read_invalid,
    output logic toggle_flag,
    output logic error_flag,
    output logic erase_window_flag,
    output logic program_start,
    output logic bulk_start,
    output logic [11:0] erase_mask,
    output logic erase_run,
    output logic array_abort
);
    fec_pkg::fec_state_t state_reg;
    fec_pkg::fec_state_t state_next;
    logic [7:0] page_reg;
    logic [7:0] space_map_reg;
    logic [7:0] rd_data_reg;
    logic status_drive_reg;
    logic read_invalid_reg;
    logic toggle_reg;
    logic error_reg;
    logic window_flag_reg;
    logic program_start_reg;
    logic bulk_start_reg;
    logic [11:0] erase_mask_reg;
    logic [11:0] erase_mask_next;
    logic erase_run_reg;
    logic abort_reg;
    logic abort_next;
    fec_pkg::fec_sel_t sel_reg;
    fec_pkg::fec_sel_t sel_next;
    logic timer_load;
    logic [fec_pkg::TMR_W-1:0] timer_value;
    logic timer_done;

    // bus decode
    wire [11:0] sector_sel = {raw_sel.secondary, raw_sel.primary};
    wire [11:0] sector_prot = {prot_secondary, prot_primary};
    wire flash_hit = |sector_sel;
    wire cmd_wr = bus.wr && !bus.cfg;
    wire even_hit = cmd_wr && !bus.addr[0] && flash_hit;
    wire is_unlock1 = cmd_wr && bus.addr[11:0] == fec_pkg::ADR_UNLOCK1
        && bus.data == fec_pkg::CMD_UNLOCK1;
    wire is_unlock2 = cmd_wr && bus.addr[11:0] == fec_pkg::ADR_UNLOCK2
        && bus.data == fec_pkg::CMD_UNLOCK2;
    wire is_reset = cmd_wr && bus.data == fec_pkg::CMD_RESET;
    wire is_suspend = even_hit && bus.data == fec_pkg::CMD_SUSPEND;
    wire is_resume = even_hit && bus.data == fec_pkg::CMD_RESUME;
    wire is_sector = cmd_wr && flash_hit && bus.data == fec_pkg::CMD_SECTOR;
    wire target_prot = |(sector_sel & sector_prot);
    wire [11:0] add_sectors = sector_sel & ~sector_prot;
    wire cfg_wr = bus.wr && bus.cfg;
    wire cfg_rd = (bus.rd || bus.fetch) && bus.cfg;
    wire flash_rd = (bus.rd || bus.fetch) && !bus.cfg && flash_hit;

    // states in which array reads return status instead of data
    wire busy = state_reg inside {fec_pkg::ST_PROGRAM, fec_pkg::ST_BULK, fec_pkg::ST_WINDOW,
        fec_pkg::ST_ERASING, fec_pkg::ST_SUSPENDING, fec_pkg::ST_ERROR, fec_pkg::ST_RECOVER};
    wire toggling = busy && state_reg != fec_pkg::ST_ERROR && state_reg != fec_pkg::ST_RECOVER;

    always_comb begin
        state_next = state_reg;
        erase_mask_next = erase_mask_reg;
        abort_next = 1'b0;
        timer_load = 1'b0;
        timer_value = fec_pkg::WINDOW_CYC;
        case (state_reg)
            fec_pkg::ST_READ: begin
                // stray suspend or resume does nothing here
                if (is_unlock1) state_next = fec_pkg::ST_UNLK1;
            end
            fec_pkg::ST_UNLK1: begin
                if (cmd_wr) state_next = is_unlock2 ? fec_pkg::ST_UNLK2 : fec_pkg::ST_READ;
            end
            fec_pkg::ST_UNLK2: begin
                if (cmd_wr) begin
                    if (bus.data == fec_pkg::CMD_PROGRAM) state_next = fec_pkg::ST_PROG_ADDR;
                    else if (bus.data == fec_pkg::CMD_ERASE_SETUP) state_next = fec_pkg::ST_ERS_SETUP;
                    else state_next = fec_pkg::ST_READ;
                end
            end
            fec_pkg::ST_PROG_ADDR: begin
                if (cmd_wr) begin
                    state_next = (flash_hit && !target_prot) ? fec_pkg::ST_PROGRAM
                        : fec_pkg::ST_READ;
                end
            end
            fec_pkg::ST_ERS_SETUP: begin
                if (cmd_wr) state_next = is_unlock1 ? fec_pkg::ST_ERS_UNLK1 : fec_pkg::ST_READ;
            end
            fec_pkg::ST_ERS_UNLK1: begin
                if (cmd_wr) state_next = is_unlock2 ? fec_pkg::ST_ERS_UNLK2 : fec_pkg::ST_READ;
            end
            fec_pkg::ST_ERS_UNLK2: begin
                if (is_sector && |add_sectors) begin
                    state_next = fec_pkg::ST_WINDOW;
                    erase_mask_next = add_sectors;
                    timer_load = 1'b1;
                end else if (cmd_wr && bus.data == fec_pkg::CMD_BULK) begin
                    state_next = fec_pkg::ST_BULK;
                end else if (cmd_wr) begin
                    state_next = fec_pkg::ST_READ;
                end
            end
            fec_pkg::ST_WINDOW: begin
                if (is_suspend) begin
                    // suspend here also closes the add-sector window
                    state_next = fec_pkg::ST_SUSPENDING;
                    timer_load = 1'b1;
                    timer_value = fec_pkg::SUSPEND_CYC;
                end else if (is_sector) begin
                    erase_mask_next = erase_mask_reg | add_sectors;
                    timer_load = 1'b1;
                end else if (cmd_wr) begin
                    state_next = fec_pkg::ST_READ;
                    erase_mask_next = '0;
                    abort_next = 1'b1;
                end else if (timer_done) begin
                    state_next = fec_pkg::ST_ERASING;
                end
            end
            fec_pkg::ST_ERASING: begin
                if (is_suspend) begin
                    state_next = fec_pkg::ST_SUSPENDING;
                    timer_load = 1'b1;
                    timer_value = fec_pkg::SUSPEND_CYC;
                end else if (is_reset) begin
                    state_next = fec_pkg::ST_RECOVER;
                    erase_mask_next = '0;
                    abort_next = 1'b1;
                    timer_load = 1'b1;
                    timer_value = fec_pkg::RECOVER_CYC;
                end else if (op_fail) begin
                    state_next = fec_pkg::ST_ERROR;
                end else if (op_done) begin
                    state_next = fec_pkg::ST_READ;
                    erase_mask_next = '0;
                end
            end
            fec_pkg::ST_SUSPENDING: begin
                if (timer_done) state_next = fec_pkg::ST_SUSPENDED;
            end
            fec_pkg::ST_SUSPENDED: begin
                // programming and everything but resume and reset is refused
                if (is_resume) begin
                    state_next = fec_pkg::ST_ERASING;
                end else if (is_reset) begin
                    state_next = fec_pkg::ST_READ;
                    erase_mask_next = '0;
                    abort_next = 1'b1;
                end
            end
            fec_pkg::ST_PROGRAM, fec_pkg::ST_BULK: begin
                // reset writes are deliberately not looked at here
                if (op_fail) state_next = fec_pkg::ST_ERROR;
                else if (op_done) state_next = fec_pkg::ST_READ;
            end
            fec_pkg::ST_ERROR: begin
                if (is_reset) begin
                    state_next = fec_pkg::ST_RECOVER;
                    erase_mask_next = '0;
                    abort_next = 1'b1;
                    timer_load = 1'b1;
                    timer_value = fec_pkg::RECOVER_CYC;
                end
            end
            fec_pkg::ST_RECOVER: begin
                if (timer_done) state_next = fec_pkg::ST_READ;
            end
            default: state_next = fec_pkg::ST_READ;
        endcase
    end

    fec_cycle_timer u_timer (
        .clk(clk),
        .nrst(nrst),
        .load(timer_load),
        .load_value(timer_value),
        .done(timer_done)
    );

    // select priority and space gating
    wire data_acc = bus.rd || bus.wr;
    wire pri_space = (bus.fetch && space_map_reg[fec_pkg::MAP_PRI_PROG])
        || (data_acc && space_map_reg[fec_pkg::MAP_PRI_DATA]);
    wire sec_space = (bus.fetch && space_map_reg[fec_pkg::MAP_SEC_PROG])
        || (data_acc && space_map_reg[fec_pkg::MAP_SEC_DATA]);
    wire sram_space = (bus.fetch && space_map_reg[fec_pkg::MAP_SRAM_PROG]) || data_acc;
    wire sram_on = raw_sel.sram && sram_space;
    wire io_on = raw_sel.io && data_acc;
    wire [3:0] sec_on = sec_space ? raw_sel.secondary : 4'h0;
    wire top_level = sram_on || io_on;
    always_comb begin
        sel_next.sram = sram_on;
        sel_next.io = io_on;
        sel_next.secondary = top_level ? 4'h0 : sec_on;
        sel_next.primary = (top_level || |sec_on || !pri_space) ? 8'h00 : raw_sel.primary;
    end

    // register read mux, unmapped offsets read as zero
    wire [7:0] cfg_rd_value =
        bus.addr[7:0] == fec_pkg::OFS_PAGE ? page_reg :
        bus.addr[7:0] == fec_pkg::OFS_PROT_PRIMARY ? prot_primary :
        bus.addr[7:0] == fec_pkg::OFS_PROT_SECONDARY ? {4'h0, prot_secondary} :
        bus.addr[7:0] == fec_pkg::OFS_SPACE_MAP ? space_map_reg : 8'h00;
    wire toggle_next = toggle_reg ^ (flash_rd && toggling);
    wire window_next = state_next inside {fec_pkg::ST_ERASING, fec_pkg::ST_SUSPENDING,
        fec_pkg::ST_SUSPENDED};
    wire error_next = op_fail ? 1'b1 : (state_reg == fec_pkg::ST_RECOVER && timer_done)
        ? 1'b0 : error_reg;
    wire [7:0] status_byte = (8'h01 << fec_pkg::STAT_TOGGLE) & {8{toggle_next}}
        | (8'h01 << fec_pkg::STAT_ERROR) & {8{error_reg}}
        | (8'h01 << fec_pkg::STAT_WINDOW) & {8{window_flag_reg}};
    wire status_now = flash_rd && busy;
    wire invalid_now = flash_rd && state_reg == fec_pkg::ST_SUSPENDED
        && |(sector_sel & erase_mask_reg);
    wire [7:0] rd_next = cfg_rd ? cfg_rd_value : (status_now ? status_byte : rd_data_reg);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= fec_pkg::ST_READ;
            erase_mask_reg <= '0;
            abort_reg <= 1'b1;
            page_reg <= fec_pkg::PAGE_RESET;
            space_map_reg <= fec_pkg::SPACE_MAP_INIT;
        end else begin
            state_reg <= state_next;
            erase_mask_reg <= erase_mask_next;
            abort_reg <= abort_next;
            if (cfg_wr && bus.addr[7:0] == fec_pkg::OFS_PAGE) page_reg <= bus.data;
            if (cfg_wr && bus.addr[7:0] == fec_pkg::OFS_SPACE_MAP) space_map_reg <= bus.data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_reg <= 8'h00;
            status_drive_reg <= 1'b0;
            read_invalid_reg <= 1'b0;
            toggle_reg <= 1'b0;
            error_reg <= 1'b0;
            window_flag_reg <= 1'b0;
            program_start_reg <= 1'b0;
            bulk_start_reg <= 1'b0;
            erase_run_reg <= 1'b0;
            sel_reg <= '0;
        end else begin
            rd_data_reg <= rd_next;
            status_drive_reg <= status_now;
            read_invalid_reg <= invalid_now;
            toggle_reg <= toggle_next;
            error_reg <= error_next;
            window_flag_reg <= window_next;
            program_start_reg <= state_reg == fec_pkg::ST_PROG_ADDR
                && state_next == fec_pkg::ST_PROGRAM;
            bulk_start_reg <= state_reg != fec_pkg::ST_BULK && state_next == fec_pkg::ST_BULK;
            erase_run_reg <= state_next == fec_pkg::ST_ERASING;
            sel_reg <= sel_next;
        end
    end

    assign sel_out = sel_reg;
    assign page_bits = page_reg;
    assign rd_data = rd_data_reg;
    assign status_drive = status_drive_reg;
    assign read_invalid = read_invalid_reg;
    assign toggle_flag = toggle_reg;
    assign error_flag = error_reg;
    assign erase_window_flag = window_flag_reg;
    assign program_start = program_start_reg;
    assign bulk_start = bulk_start_reg;
    assign erase_mask = erase_mask_reg;
    assign erase_run = erase_run_reg;
    assign array_abort = abort_reg;
endmodule : fec_flash_ctrl

// [dv/fec_flash_ctrl_asserts.sv]
// fec_flash_ctrl_asserts: port-level checks of the flash erase control block.
// Assumes it is bound onto fec_flash_ctrl and sees only its ports.
`timescale 1ns/100ps
module fec_flash_ctrl_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire fec_pkg::fec_bus_t bus,
    input wire fec_pkg::fec_sel_t raw_sel,
    input wire logic [7:0] prot_primary,
    input wire logic op_done,
    input wire logic op_fail,
    input wire fec_pkg::fec_sel_t sel_out,
    input wire logic [7:0] page_bits,
    input wire logic [7:0] rd_data,
    input wire logic read_invalid,
    input wire logic erase_window_flag,
    input wire logic program_start,
    input wire logic erase_run,
    input wire logic array_abort
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire sect = |{raw_sel.primary, raw_sel.secondary};
    wire cfg_wr = bus.wr && bus.cfg;
    wire cfg_rd = bus.rd && bus.cfg && !bus.wr;
    // completion in the same cycle may end the erase legitimately
    wire b0_wr = bus.wr && !bus.cfg && bus.data == fec_pkg::CMD_SUSPEND && !op_done && !op_fail;
    wire dat_rd = bus.rd && !bus.fetch && !bus.cfg;

    a_page_write: assert property (cfg_wr && bus.addr[7:0] == fec_pkg::OFS_PAGE
        |=> page_bits == $past(bus.data)) else $error("page write not stored");
    a_page_read: assert property (cfg_rd && bus.addr[7:0] == fec_pkg::OFS_PAGE
        |=> rd_data == $past(page_bits)) else $error("page read wrong");
    a_prot_read: assert property (cfg_rd && bus.addr[7:0] == fec_pkg::OFS_PROT_PRIMARY
        |=> rd_data == $past(prot_primary)) else $error("protect read wrong");
    a_page_clear: assert property ($rose(nrst) |-> page_bits == fec_pkg::PAGE_RESET)
        else $error("page not cleared by reset");
    a_abort_release: assert property ($rose(nrst) |-> array_abort ##1 !array_abort)
        else $error("abort not held through reset");
    a_suspend_stops: assert property (b0_wr && !bus.addr[0] && sect && erase_run
        |=> !erase_run && erase_window_flag) else $error("suspend not taken");
    a_suspend_nosel: assert property (b0_wr && !sect && erase_run |=> erase_run)
        else $error("suspend without select taken");
    a_run_flag: assert property (erase_run |-> erase_window_flag)
        else $error("window flag low while erasing");
    a_sram_first: assert property (dat_rd && raw_sel.sram |=> sel_out.sram
        && sel_out.primary == 8'h00 && sel_out.secondary == 4'h0) else $error("sram lost");
    a_sec_first: assert property (dat_rd && |raw_sel.secondary && !raw_sel.sram
        && !raw_sel.io |=> sel_out.primary == 8'h00) else $error("primary beat secondary");

    c_suspend: cover property (b0_wr && sect && erase_run);
    c_program: cover property (program_start);
    c_invalid: cover property (read_invalid);
endmodule : fec_flash_ctrl_asserts

bind fec_flash_ctrl fec_flash_ctrl_asserts fec_flash_ctrl_asserts_inst (.*);

// [dv/fec_array_model.sv]
// fec_array_model: behavioural flash array answering program and erase starts.
// Assumes single-cycle start pulses; fail_req turns the next completion into a failure.
`timescale 1ns/100ps
module fec_array_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic program_start,
    input wire logic bulk_start,
    input wire logic erase_run,
    input wire logic array_abort,
    input wire logic fail_req,
    output logic op_done,
    output logic op_fail
);
    localparam int PROG_CYC = 40;
    localparam int ERASE_CYC = 3000;
    int busy_cnt;
    int erase_cnt;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt <= 0;
            erase_cnt <= 0;
            op_done <= 1'b0;
            op_fail <= 1'b0;
        end else begin
            op_done <= (busy_cnt == 1 || erase_cnt == ERASE_CYC) && !fail_req;
            op_fail <= (busy_cnt == 1 || erase_cnt == ERASE_CYC) && fail_req;
            // erase progress only accrues while running, so suspend pauses it
            erase_cnt <= (array_abort || erase_cnt == ERASE_CYC) ? 0 : erase_cnt + int'(erase_run);
            if (array_abort) busy_cnt <= 0;
            else if (program_start || bulk_start) busy_cnt <= PROG_CYC;
            else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
        end
    end
endmodule : fec_array_model

// [dv/fec_flash_ctrl_bench.sv]
// fec_flash_ctrl_bench: directed tests of the flash erase control block.
// Assumes fec_array_model as the array and the bound port checker.
`timescale 1ns/100ps
module fec_flash_ctrl_bench;
    logic clk, nrst, op_done, op_fail, fail_req, t;
    fec_pkg::fec_bus_t bus;
    fec_pkg::fec_sel_t raw_sel, sel_out;
    logic [7:0] prot_primary, page_bits, rd_data;
    logic [3:0] prot_secondary;
    logic [11:0] erase_mask;
    logic status_drive, read_invalid, toggle_flag, error_flag, erase_window_flag;
    logic program_start, bulk_start, erase_run, array_abort;
    int error_cnt = 0, comparisons = 0, pcnt = 0, cycles = 0;

    fec_flash_ctrl fec_flash_ctrl_inst (.*);
    fec_array_model fec_array_model_inst (.*);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        pcnt <= pcnt + int'(program_start);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude;
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic fec_pkg::fec_sel_t sp(input logic [7:0] p, input logic [3:0] s,
        input logic [1:0] m);
        return {p, s, m};
    endfunction : sp
    task automatic acc(input logic w, c, f, input logic [15:0] a, input logic [7:0] d,
        input fec_pkg::fec_sel_t s);
        @(negedge clk);
        bus = '{addr: a, data: d, wr: w, rd: !w && !f, fetch: f, cfg: c};
        raw_sel = s;
        @(negedge clk);
        bus = '{addr: ~a, data: ~d, default: 1'b0};
        raw_sel = '0;
    endtask : acc
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input fec_pkg::fec_sel_t s);
        acc(1'b1, 1'b0, 1'b0, a, d, s);
    endtask : wr
    task automatic rd(input logic [15:0] a, input fec_pkg::fec_sel_t s);
        acc(1'b0, 1'b0, 1'b0, a, 8'h00, s);
    endtask : rd
    task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
        acc(w, 1'b1, 1'b0, {8'h00, a}, d, '0);
    endtask : cfg
    task automatic ul;
        wr({4'h0, fec_pkg::ADR_UNLOCK1}, fec_pkg::CMD_UNLOCK1, '0);
        wr({4'h0, fec_pkg::ADR_UNLOCK2}, fec_pkg::CMD_UNLOCK2, '0);
    endtask : ul
    task automatic prog(input fec_pkg::fec_sel_t s);
        ul();
        wr(16'h0000, fec_pkg::CMD_PROGRAM, '0);
        wr(16'h0010, 8'h5A, s);
    endtask : prog
    task automatic erase(input fec_pkg::fec_sel_t s);
        ul();
        wr({4'h0, fec_pkg::ADR_UNLOCK1}, fec_pkg::CMD_ERASE_SETUP, '0);
        ul();
        wr(16'h0100, fec_pkg::CMD_SECTOR, s);
    endtask : erase

    initial begin
        bus = '0;
        raw_sel = '0;
        prot_primary = 8'h01;
        prot_secondary = 4'h2;
        fail_req = 1'b0;
        nrst = 1'b0;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        chk(page_bits, fec_pkg::PAGE_RESET);
        cfg(1'b0, fec_pkg::OFS_SPACE_MAP, 8'h00);
        chk(rd_data, fec_pkg::SPACE_MAP_INIT);
        cfg(1'b1, fec_pkg::OFS_PAGE, 8'hA5);
        chk(page_bits, 8'hA5);
        cfg(1'b0, fec_pkg::OFS_PAGE, 8'h00);
        chk(rd_data, 8'hA5);
        cfg(1'b1, fec_pkg::OFS_PROT_PRIMARY, 8'h00);
        cfg(1'b0, fec_pkg::OFS_PROT_PRIMARY, 8'h00);
        chk(rd_data, 8'h01);
        cfg(1'b0, fec_pkg::OFS_PROT_SECONDARY, 8'h00);
        chk(rd_data[3:0], 4'h2);
        acc(1'b0, 1'b0, 1'b1, 16'h0000, 8'h00, sp(8'h01, 4'h0, 2'b00));
        chk(sel_out.primary, 8'h01);
        rd(16'h0000, sp(8'h01, 4'h0, 2'b00));
        chk(sel_out.primary, 8'h00);
        cfg(1'b1, fec_pkg::OFS_SPACE_MAP, 8'h1C);
        rd(16'h0000, sp(8'h01, 4'h0, 2'b00));
        chk(sel_out.primary, 8'h01);
        rd(16'h8000, sp(8'h01, 4'h1, 2'b10));
        chk(sel_out, sp(8'h00, 4'h0, 2'b10));
        rd(16'h8800, sp(8'h01, 4'h1, 2'b00));
        chk(sel_out, sp(8'h00, 4'h1, 2'b00));
        wr(16'h0100, fec_pkg::CMD_SUSPEND, sp(8'h02, 4'h0, 2'b00));
        chk(erase_window_flag, 1'b0);
        prog(sp(8'h01, 4'h0, 2'b00));
        prog(sp(8'h04, 4'h0, 2'b00));
        wr(16'h0000, fec_pkg::CMD_RESET, '0);
        rd(16'h0010, sp(8'h04, 4'h0, 2'b00));
        chk(status_drive, 1'b1);
        chk(16'(pcnt), 16'h0001);
        fail_req = 1'b1;
        repeat (50) @(negedge clk);
        prog(sp(8'h04, 4'h0, 2'b00));
        repeat (50) @(negedge clk);
        chk(error_flag, 1'b1);
        wr(16'h0000, fec_pkg::CMD_RESET, '0);
        fail_req = 1'b0;
        repeat (505) @(negedge clk);
        chk(error_flag, 1'b0);
        erase(sp(8'h03, 4'h0, 2'b00));
        chk(erase_window_flag, 1'b0);
        chk(16'(erase_mask), 16'h0002);
        repeat (2005) @(negedge clk);
        chk(erase_run, 1'b1);
        rd(16'h0100, sp(8'h02, 4'h0, 2'b00));
        t = toggle_flag;
        rd(16'h0100, sp(8'h02, 4'h0, 2'b00));
        chk(toggle_flag, !t);
        wr(16'h0101, fec_pkg::CMD_SUSPEND, sp(8'h02, 4'h0, 2'b00));
        chk(erase_run, 1'b1);
        wr(16'h0100, fec_pkg::CMD_SUSPEND, '0);
        chk(erase_run, 1'b1);
        wr(16'h0100, fec_pkg::CMD_SUSPEND, sp(8'h02, 4'h0, 2'b00));
        chk(erase_run, 1'b0);
        repeat (4) @(negedge clk);
        rd(16'h0100, sp(8'h02, 4'h0, 2'b00));
        t = toggle_flag;
        chk(read_invalid, 1'b1);
        rd(16'h0100, sp(8'h02, 4'h0, 2'b00));
        chk(toggle_flag, t);
        prog(sp(8'h08, 4'h0, 2'b00));
        chk(16'(pcnt), 16'h0001);
        rd(16'h0200, sp(8'h08, 4'h0, 2'b00));
        chk(read_invalid, 1'b0);
        wr(16'h0100, fec_pkg::CMD_RESUME, sp(8'h02, 4'h0, 2'b00));
        chk(erase_run, 1'b1);
        wr(16'h0000, fec_pkg::CMD_RESET, '0);
        chk(erase_run, 1'b0);
        repeat (505) @(negedge clk);
        wr(16'h0100, fec_pkg::CMD_SUSPEND, sp(8'h02, 4'h0, 2'b00));
        chk(erase_window_flag, 1'b0);
        erase(sp(8'h02, 4'h0, 2'b00));
        repeat (10) @(negedge clk);
        wr(16'h0100, fec_pkg::CMD_SUSPEND, sp(8'h02, 4'h0, 2'b00));
        repeat (3) @(negedge clk);
        chk(erase_window_flag, 1'b1);
        repeat (2100) @(negedge clk);
        chk(erase_run, 1'b0);
        ul();
        wr(16'h0000, fec_pkg::CMD_RESET, '0);
        wr(16'h0100, fec_pkg::CMD_RESUME, sp(8'h02, 4'h0, 2'b00));
        chk(erase_run, 1'b0);
        chk(erase_window_flag, 1'b0);
        cfg(1'b1, fec_pkg::OFS_PAGE, 8'h3C);
        nrst = 1'b0;
        repeat (500) @(negedge clk);
        chk(page_bits, 8'h00);
        nrst = 1'b1;
        cfg(1'b0, fec_pkg::OFS_SPACE_MAP, 8'h00);
        chk(rd_data, fec_pkg::SPACE_MAP_INIT);
        conclude();
    end
endmodule : fec_flash_ctrl_bench
